// ---- verilog/status_irq_pkg.sv ----
// shared constants and types for the framer status latch and interrupt block
package status_irq_pkg;
   // register slots inside one framer
   localparam int NUM_LATCHED = 9;
   localparam logic [3:0] IDX_STATUS_A = 4'h0;
   localparam logic [3:0] IDX_STATUS_B = 4'h1;
   localparam logic [3:0] IDX_INFO_A = 4'h2;
   localparam logic [3:0] IDX_INFO_B = 4'h3;
   localparam logic [3:0] IDX_INFO_C = 4'h4;
   localparam logic [3:0] IDX_LINK_STATUS = 4'h5;
   localparam logic [3:0] IDX_FACILITY_STATUS = 4'h6;
   localparam logic [3:0] IDX_LINK_RX_STATUS = 4'h7;
   localparam logic [3:0] IDX_LINK_TX_STATUS = 4'h8;
   localparam logic [3:0] IDX_MASK_A = 4'h9;
   localparam logic [3:0] IDX_MASK_B = 4'ha;
   localparam logic [3:0] IDX_LINK_MASK = 4'hb;
   localparam logic [3:0] IDX_NONE = 4'hf;
   // byte offsets on the parallel port
   localparam logic [7:0] OFS_STATUS_A = 8'h16;
   localparam logic [7:0] OFS_STATUS_B = 8'h17;
   localparam logic [7:0] OFS_INFO_A = 8'h22;
   localparam logic [7:0] OFS_INFO_B = 8'h31;
   localparam logic [7:0] OFS_INFO_C = 8'h10;
   localparam logic [7:0] OFS_LINK_STATUS = 8'h90;
   localparam logic [7:0] OFS_FACILITY_STATUS = 8'h91;
   localparam logic [7:0] OFS_LINK_RX_STATUS = 8'h92;
   localparam logic [7:0] OFS_LINK_TX_STATUS = 8'h93;
   localparam logic [7:0] OFS_MASK_A = 8'h7f;
   localparam logic [7:0] OFS_MASK_B = 8'h6f;
   localparam logic [7:0] OFS_LINK_MASK = 8'h94;
   localparam logic [7:0] OFS_SUMMARY_LO = 8'ha0;
   // status_a field layout: bits 0..4 are alarm levels, 5..7 events
   localparam int POS_RX_YELLOW = 0;
   localparam int POS_CARRIER_LOSS = 1;
   localparam int POS_BLUE_ALARM = 2;
   localparam int POS_SYNC_LOSS = 3;
   localparam int POS_TX_CLOCK_LOSS = 4;
   localparam int NUM_ALARMS = 5;
   localparam logic [7:0] ALARM_BITS = 8'h1f;
   localparam logic [7:0] PERSIST_BITS = 8'h0f;
   // reset values
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_RDATA = 8'h00;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;

   // one host access on the parallel port, one cycle long
   typedef struct packed {
      logic wr;
      logic rd;
      logic [1:0] fsel;
      logic [7:0] addr;
      logic [7:0] wdata;
   } host_req_t;
endpackage : status_irq_pkg

// ---- verilog/framer_status_latch_irq.sv ----
// latched status registers, masked read scheme and interrupt summary for four framers
// Functional notes
// [RULE1] each framer keeps nine latched status and information registers.
// [RULE2] status and information bits latch to one on their event and stay until read.
// [RULE3] a read clears a latched bit, but yellow, carrier, blue and sync alarms re-set while present.
// [RULE4] writing a one to a bit position loads the readable copy with the latest latched value.
// [RULE5] writing a zero to a bit position leaves the readable copy holding its old value.
// [RULE6] the host writes a mask byte before each read and reads the same register right after.
// [RULE7] the host writes back the value read anded with its mask so reported bits really clear.
// [RULE8] status_a, status_b and link status bits drive the low interrupt through per-bit masks.
// [RULE9] the five status_a alarm bits are alarm sources, all other sources are event sources.
// [RULE10] an unmasked alarm requests an interrupt on each change, going active or inactive.
// [RULE11] an alarm request is withdrawn when its bit is read even if the alarm persists.
// [RULE12] an unmasked event requests an interrupt when it occurs and is withdrawn when read.
// [RULE13] the interrupt output goes high only when no request is pending in any framer.
// [RULE14] any read address from a0 to ff returns the interrupt summary.
// [RULE15] summary bit 2n flags framer n status requests and bit 2n+1 its link requests.
// [RULE16] reading the summary clears nothing and does not release the interrupt.
`timescale 1ns/1ps
`default_nettype none
module framer_status_latch_irq #(
   parameter int NF = 4
) (
   input wire logic clk_sys, // 10 MHz system clock
   input wire logic rst_b, // asynchronous reset, active low
   input wire status_irq_pkg::host_req_t hostReq, // one-cycle parallel port access
   input wire logic [7:0] srcIn [NF][status_irq_pkg::NUM_LATCHED], // event pulses and alarm levels
   output logic [7:0] rdData, // read answer, registered
   output logic rdValid, // pulse one cycle after a read
   output logic irqOut_b // interrupt request, active low
);

   // map an address to a register slot
   function automatic logic [3:0] decodeSlot(input logic [7:0] a);
      case (a)
         status_irq_pkg::OFS_STATUS_A: decodeSlot = status_irq_pkg::IDX_STATUS_A;
         status_irq_pkg::OFS_STATUS_B: decodeSlot = status_irq_pkg::IDX_STATUS_B;
         status_irq_pkg::OFS_INFO_A: decodeSlot = status_irq_pkg::IDX_INFO_A;
         status_irq_pkg::OFS_INFO_B: decodeSlot = status_irq_pkg::IDX_INFO_B;
         status_irq_pkg::OFS_INFO_C: decodeSlot = status_irq_pkg::IDX_INFO_C;
         status_irq_pkg::OFS_LINK_STATUS: decodeSlot = status_irq_pkg::IDX_LINK_STATUS;
         status_irq_pkg::OFS_FACILITY_STATUS: decodeSlot = status_irq_pkg::IDX_FACILITY_STATUS;
         status_irq_pkg::OFS_LINK_RX_STATUS: decodeSlot = status_irq_pkg::IDX_LINK_RX_STATUS;
         status_irq_pkg::OFS_LINK_TX_STATUS: decodeSlot = status_irq_pkg::IDX_LINK_TX_STATUS;
         status_irq_pkg::OFS_MASK_A: decodeSlot = status_irq_pkg::IDX_MASK_A;
         status_irq_pkg::OFS_MASK_B: decodeSlot = status_irq_pkg::IDX_MASK_B;
         status_irq_pkg::OFS_LINK_MASK: decodeSlot = status_irq_pkg::IDX_LINK_MASK;
         default: decodeSlot = status_irq_pkg::IDX_NONE;
      endcase
   endfunction : decodeSlot

   logic [7:0] latch_r [NF][status_irq_pkg::NUM_LATCHED]; // hardware-set bits
   logic [7:0] copy_r [NF][status_irq_pkg::NUM_LATCHED]; // host-readable copies
   logic [7:0] lastMask_r [NF][status_irq_pkg::NUM_LATCHED]; // bits asked for by the last write
   logic [7:0] maskA_r [NF];
   logic [7:0] maskB_r [NF];
   logic [7:0] linkMask_r [NF];
   logic [status_irq_pkg::NUM_ALARMS-1:0] alarmPrev_r [NF]; // alarm levels one cycle ago
   logic [status_irq_pkg::NUM_ALARMS-1:0] alarmChg_r [NF]; // alarm changed, not yet read
   logic [7:0] summary;
   logic [3:0] slot;
   logic sumHit;

   // address decode
   assign slot = decodeSlot(hostReq.addr);
   assign sumHit = hostReq.addr >= status_irq_pkg::OFS_SUMMARY_LO; // a0..ff [RULE14]

   // latched bits: set wins over the clear by a read
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         for (int f = 0; f < NF; f++) begin
            for (int r = 0; r < status_irq_pkg::NUM_LATCHED; r++) begin
               latch_r[f][r] <= status_irq_pkg::RST_LATCH;
            end
         end
      end else begin
         for (int f = 0; f < NF; f++) begin
            for (int r = 0; r < status_irq_pkg::NUM_LATCHED; r++) begin
               logic [7:0] setv;
               logic [7:0] clrv;
               setv = srcIn[f][r];
               clrv = 8'h00;
               if (r == 0) begin
                  // persistent alarms follow the level, tx clock loss latches its rising edge
                  setv = (srcIn[f][r] & ~status_irq_pkg::ALARM_BITS) // [RULE3]
                     | (srcIn[f][r] & status_irq_pkg::PERSIST_BITS)
                     | ({3'h0, srcIn[f][r][status_irq_pkg::NUM_ALARMS-1:0] & ~alarmPrev_r[f]}
                        & ~status_irq_pkg::PERSIST_BITS);
               end
               if (hostReq.rd && !sumHit && hostReq.fsel == f[1:0] && slot == r[3:0]) begin
                  clrv = lastMask_r[f][r]; // read clears the bits asked for [RULE3]
               end
               latch_r[f][r] <= (latch_r[f][r] & ~clrv) | setv; // [RULE1] [RULE2]
            end
         end
      end
   end

   // readable copies: ones load latest latched value, zeros hold
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         for (int f = 0; f < NF; f++) begin
            for (int r = 0; r < status_irq_pkg::NUM_LATCHED; r++) begin
               copy_r[f][r] <= status_irq_pkg::RST_LATCH;
               lastMask_r[f][r] <= status_irq_pkg::RST_MASK;
            end
         end
      end else begin
         for (int f = 0; f < NF; f++) begin
            for (int r = 0; r < status_irq_pkg::NUM_LATCHED; r++) begin
               if (hostReq.wr && !sumHit && hostReq.fsel == f[1:0] && slot == r[3:0]) begin
                  copy_r[f][r] <= (copy_r[f][r] & ~hostReq.wdata) // [RULE5]
                     | (latch_r[f][r] & hostReq.wdata); // [RULE4]
                  lastMask_r[f][r] <= hostReq.wdata;
               end
            end
         end
      end
   end

   // interrupt mask registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         for (int f = 0; f < NF; f++) begin
            maskA_r[f] <= status_irq_pkg::RST_MASK;
            maskB_r[f] <= status_irq_pkg::RST_MASK;
            linkMask_r[f] <= status_irq_pkg::RST_MASK;
         end
      end else begin
         for (int f = 0; f < NF; f++) begin
            if (hostReq.wr && !sumHit && hostReq.fsel == f[1:0]) begin
               if (slot == status_irq_pkg::IDX_MASK_A) begin
                  maskA_r[f] <= hostReq.wdata; // [RULE8]
               end
               if (slot == status_irq_pkg::IDX_MASK_B) begin
                  maskB_r[f] <= hostReq.wdata;
               end
               if (slot == status_irq_pkg::IDX_LINK_MASK) begin
                  linkMask_r[f] <= hostReq.wdata;
               end
            end
         end
      end
   end

   // alarm change tracking for alarm-type interrupt sources
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         for (int f = 0; f < NF; f++) begin
            alarmPrev_r[f] <= '0;
            alarmChg_r[f] <= '0;
         end
      end else begin
         for (int f = 0; f < NF; f++) begin
            logic [status_irq_pkg::NUM_ALARMS-1:0] cur;
            logic [status_irq_pkg::NUM_ALARMS-1:0] clr;
            cur = srcIn[f][0][status_irq_pkg::NUM_ALARMS-1:0];
            clr = '0;
            if (hostReq.rd && !sumHit && hostReq.fsel == f[1:0] && slot == status_irq_pkg::IDX_STATUS_A) begin
               clr = lastMask_r[f][0][status_irq_pkg::NUM_ALARMS-1:0]; // [RULE11]
            end
            alarmPrev_r[f] <= cur;
            alarmChg_r[f] <= (alarmChg_r[f] & ~clr) | (cur ^ alarmPrev_r[f]); // [RULE9] [RULE10]
         end
      end
   end

   // per-framer request summary
   always_comb begin
      summary = 8'h00;
      for (int f = 0; f < NF; f++) begin
         summary[2*f] = |(alarmChg_r[f] & maskA_r[f][status_irq_pkg::NUM_ALARMS-1:0]) // [RULE15]
            | |(latch_r[f][0] & ~status_irq_pkg::ALARM_BITS & maskA_r[f]) // [RULE12]
            | |(latch_r[f][1] & maskB_r[f]);
         summary[2*f+1] = |(latch_r[f][5] & linkMask_r[f]); // [RULE8]
      end
   end

   // interrupt pin: high only with nothing pending anywhere
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irqOut_b <= 1'b1;
      end else begin
         irqOut_b <= ~|summary; // [RULE13]
      end
   end

   // read path; summary reads have no side effect
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdData <= status_irq_pkg::RST_RDATA;
         rdValid <= 1'b0;
      end else begin
         rdValid <= hostReq.rd;
         if (hostReq.rd) begin
            if (sumHit) begin
               rdData <= summary; // [RULE14] [RULE16]
            end else if (slot < 4'(status_irq_pkg::NUM_LATCHED)) begin
               rdData <= copy_r[hostReq.fsel][slot];
            end else if (slot == status_irq_pkg::IDX_MASK_A) begin
               rdData <= maskA_r[hostReq.fsel];
            end else if (slot == status_irq_pkg::IDX_MASK_B) begin
               rdData <= maskB_r[hostReq.fsel];
            end else if (slot == status_irq_pkg::IDX_LINK_MASK) begin
               rdData <= linkMask_r[hostReq.fsel];
            end else begin
               rdData <= status_irq_pkg::UNMAPPED_DATA;
            end
         end
      end
   end

   // checks on framer 1 info_a, framer 0 status_a and the requests of framers 2 and 3
   logic infoWr;
   logic infoRd;
   logic stat0Rd;
   assign infoWr = hostReq.wr && !sumHit && hostReq.fsel == 2'h1 && slot == status_irq_pkg::IDX_INFO_A;
   assign infoRd = hostReq.rd && !sumHit && hostReq.fsel == 2'h1 && slot == status_irq_pkg::IDX_INFO_A;
   assign stat0Rd = hostReq.rd && !sumHit && hostReq.fsel == 2'h0 && slot == status_irq_pkg::IDX_STATUS_A;

   a_latch_holds: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE2]
      (latch_r[1][2][1] && !(infoRd && lastMask_r[1][2][1])) |=> latch_r[1][2][1])
      else $error("latched bit dropped without a read");

   a_read_clears: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE3]
      (infoRd && lastMask_r[1][2][1] && !srcIn[1][2][1]) |=> !latch_r[1][2][1])
      else $error("read did not clear latched bit");

   a_alarm_persists: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE3]
      srcIn[0][0][status_irq_pkg::POS_BLUE_ALARM] |=> latch_r[0][0][status_irq_pkg::POS_BLUE_ALARM])
      else $error("persistent alarm bit not held");

   a_tx_edge: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE9]
      $rose(srcIn[0][0][status_irq_pkg::POS_TX_CLOCK_LOSS])
      |=> latch_r[0][0][status_irq_pkg::POS_TX_CLOCK_LOSS])
      else $error("clock loss edge not latched");

   a_tx_clears: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE3]
      (stat0Rd && lastMask_r[0][0][status_irq_pkg::POS_TX_CLOCK_LOSS]
       && alarmPrev_r[0][status_irq_pkg::POS_TX_CLOCK_LOSS] && srcIn[0][0][status_irq_pkg::POS_TX_CLOCK_LOSS])
      |=> !latch_r[0][0][status_irq_pkg::POS_TX_CLOCK_LOSS])
      else $error("clock loss bit not cleared by read");

   a_copy_loads: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE4]
      infoWr |=> ((copy_r[1][2] ^ $past(latch_r[1][2])) & $past(hostReq.wdata)) == 8'h00)
      else $error("mask write did not load copy");

   a_copy_holds: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE5]
      infoWr |=> ((copy_r[1][2] ^ $past(copy_r[1][2])) & ~$past(hostReq.wdata)) == 8'h00)
      else $error("zero mask changed copy");

   a_copy_read: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE4]
      infoRd |=> rdValid && rdData == $past(copy_r[1][2]))
      else $error("read did not return readable copy");

   a_alarm_change: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE10]
      (srcIn[0][0][status_irq_pkg::POS_BLUE_ALARM] != alarmPrev_r[0][status_irq_pkg::POS_BLUE_ALARM])
      |=> alarmChg_r[0][status_irq_pkg::POS_BLUE_ALARM])
      else $error("alarm change not recorded");

   a_alarm_withdraw: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE11]
      (stat0Rd && lastMask_r[0][0][status_irq_pkg::POS_BLUE_ALARM]
       && srcIn[0][0][status_irq_pkg::POS_BLUE_ALARM] == alarmPrev_r[0][status_irq_pkg::POS_BLUE_ALARM])
      |=> !alarmChg_r[0][status_irq_pkg::POS_BLUE_ALARM])
      else $error("alarm request not withdrawn by read");

   a_alarm_irq: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE10]
      (alarmChg_r[2][status_irq_pkg::POS_BLUE_ALARM] && maskA_r[2][status_irq_pkg::POS_BLUE_ALARM])
      |=> !irqOut_b)
      else $error("unmasked alarm change did not pull interrupt low");

   a_event_irq: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE12]
      (|(latch_r[3][1] & maskB_r[3])) |=> !irqOut_b)
      else $error("unmasked event did not pull interrupt low");

   a_event_withdraw: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE12]
      (hostReq.rd && !sumHit && hostReq.fsel == 2'h3 && slot == status_irq_pkg::IDX_STATUS_B
       && lastMask_r[3][1][7] && !srcIn[3][1][7]) |=> !latch_r[3][1][7])
      else $error("event bit not cleared by read");

   a_link_irq: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE8]
      (|(latch_r[3][5] & linkMask_r[3])) |=> !irqOut_b)
      else $error("unmasked link event did not pull interrupt low");

   a_masked_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE8]
      (maskA_r[0] == 8'h00 && maskB_r[0] == 8'h00 && linkMask_r[0] == 8'h00) |-> summary[1:0] == 2'h0)
      else $error("fully masked framer shows a request");

   a_irq_release: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE13]
      (summary == 8'h00) |=> irqOut_b)
      else $error("interrupt low with nothing pending");

   a_summary_read: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE14]
      (hostReq.rd && hostReq.addr >= 8'ha0) |=> (rdValid && rdData == $past(summary)))
      else $error("summary not returned");

   a_summary_status: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE15]
      (|(latch_r[3][1] & maskB_r[3])) |-> summary[6])
      else $error("status request missing from summary");

   a_summary_link: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE15]
      (|(latch_r[3][5] & linkMask_r[3])) |-> summary[7])
      else $error("link request missing from summary");

   a_summary_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE16]
      (hostReq.rd && sumHit && srcIn[3][1] == 8'h00) |=> $stable(latch_r[3][1]))
      else $error("summary read disturbed latched bits");

endmodule : framer_status_latch_irq
`default_nettype wire

// ---- dv/host_cpu_model.sv ----
// host processor model driving the parallel port with the masked poll scheme
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
   input wire logic clk_sys, // system clock
   output var status_irq_pkg::host_req_t hostReq, // one-cycle access
   input wire logic [7:0] rdData, // read answer
   input wire logic rdValid // read answer strobe
);
   initial hostReq = '0;
   // raise after an edge, hold through the taking edge, then drop
   task automatic access(input logic w, input logic r, input logic [1:0] f, input logic [7:0] a,
                         input logic [7:0] d);
      @(posedge clk_sys);
      hostReq <= status_irq_pkg::host_req_t'{wr: w, rd: r, fsel: f, addr: a, wdata: d};
      @(posedge clk_sys);
      hostReq <= '0;
   endtask : access
   task automatic write(input logic [1:0] f, input logic [7:0] a, input logic [7:0] d);
      access(1'b1, 1'b0, f, a, d);
   endtask : write
   // answer strobe is awaited under a bound; a missing answer yields unknown data
   task automatic read(input logic [1:0] f, input logic [7:0] a, output logic [7:0] d);
      int n;
      n = 0;
      access(1'b0, 1'b1, f, a, 8'h00);
      #1;
      while (rdValid !== 1'b1 && n < 8) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      d = (rdValid === 1'b1) ? rdData : 8'hxx;
   endtask : read
   // mask write, read right after, then write back the read anded with the mask
   task automatic poll(input logic [1:0] f, input logic [7:0] a, input logic [7:0] m, output logic [7:0] d);
      write(f, a, m);
      read(f, a, d);
      write(f, a, d & m);
   endtask : poll
endmodule : host_cpu_model
`default_nettype wire

// ---- dv/framer_status_latch_irq_test.sv ----
// self-checking bench for the framer status latch and interrupt block
`timescale 1ns/1ps
`default_nettype none
module framer_status_latch_irq_test;
   localparam int LIMIT = 20000; // far above the run length
   logic clk_sys;
   logic rst_b;
   status_irq_pkg::host_req_t hostReq;
   logic [7:0] src [4][status_irq_pkg::NUM_LATCHED];
   logic [7:0] rdData;
   logic rdValid;
   logic irqOut_b;
   logic [7:0] v;
   logic [7:0] ofs [9];
   int errTotal = 0;
   int compares = 0;
   int cycles = 0;

   framer_status_latch_irq #(.NF(4)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .hostReq(hostReq), .srcIn(src),
      .rdData(rdData), .rdValid(rdValid), .irqOut_b(irqOut_b));
   host_cpu_model host (.clk_sys(clk_sys), .hostReq(hostReq), .rdData(rdData), .rdValid(rdValid));

   // 10 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         errTotal++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, errTotal);
      if (errTotal == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   task automatic pulse(input int f, input int s, input logic [7:0] b);
      @(posedge clk_sys);
      src[f][s] <= b;
      @(posedge clk_sys);
      src[f][s] <= 8'h00;
   endtask : pulse
   task automatic level(input int f, input logic [7:0] b);
      @(posedge clk_sys);
      src[f][0] <= b;
   endtask : level
   // latch plus registered interrupt take two edges; one spare
   task automatic settle();
      repeat (3) @(posedge clk_sys);
      #1;
   endtask : settle
   // hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles >= LIMIT) begin
         errTotal++;
         summarize();
      end
   end
   // main sequence
   initial begin
      rst_b = 1'b0;
      ofs = '{status_irq_pkg::OFS_STATUS_A, status_irq_pkg::OFS_STATUS_B, status_irq_pkg::OFS_INFO_A,
         status_irq_pkg::OFS_INFO_B, status_irq_pkg::OFS_INFO_C, status_irq_pkg::OFS_LINK_STATUS,
         status_irq_pkg::OFS_FACILITY_STATUS, status_irq_pkg::OFS_LINK_RX_STATUS, status_irq_pkg::OFS_LINK_TX_STATUS};
      for (int f = 0; f < 4; f++) for (int s = 0; s < 9; s++) src[f][s] = 8'h00;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      settle();
      check("irq reset", {7'h00, irqOut_b}, 8'h01);
      host.write(2'd0, 8'ha0, 8'hff);
      host.read(2'd0, 8'hc3, v);
      check("summary ro", v, 8'h00);
      host.read(2'd0, 8'h05, v);
      check("unmapped", v, 8'h00);
      // every one of the nine slots latches a pulse driven into all nine at once
      @(posedge clk_sys);
      for (int s = 0; s < 9; s++) src[3][s] <= 8'h80;
      @(posedge clk_sys);
      for (int s = 0; s < 9; s++) src[3][s] <= 8'h00;
      for (int s = 0; s < 9; s++) begin
         host.poll(2'd3, ofs[s], 8'h80, v);
         check("slot", v, 8'h80);
      end
      // latch, clear on read, zero mask holds the copy
      pulse(1, 2, 8'h40);
      host.poll(2'd1, status_irq_pkg::OFS_INFO_A, 8'h40, v);
      check("info set", v, 8'h40);
      host.poll(2'd1, status_irq_pkg::OFS_INFO_A, 8'h40, v);
      check("info clear", v, 8'h00);
      pulse(1, 2, 8'h02);
      host.write(2'd1, status_irq_pkg::OFS_INFO_A, 8'h00);
      host.read(2'd1, status_irq_pkg::OFS_INFO_A, v);
      check("info held", v, 8'h00);
      host.poll(2'd1, status_irq_pkg::OFS_INFO_A, 8'h02, v);
      check("info late", v, 8'h02);
      // blue persists, tx clock loss does not; masked so no interrupt
      level(0, 8'h14);
      host.poll(2'd0, status_irq_pkg::OFS_STATUS_A, 8'h14, v);
      check("alarm set", v, 8'h14);
      host.poll(2'd0, status_irq_pkg::OFS_STATUS_A, 8'h14, v);
      check("alarm persist", v, 8'h04);
      check("irq masked", {7'h00, irqOut_b}, 8'h01);
      level(0, 8'h00);
      host.poll(2'd0, status_irq_pkg::OFS_STATUS_A, 8'hff, v);
      // alarm interrupt on both edges of the alarm
      host.write(2'd2, status_irq_pkg::OFS_MASK_A, 8'h04);
      level(2, 8'h04);
      settle();
      check("irq alarm on", {7'h00, irqOut_b}, 8'h00);
      host.read(2'd0, 8'ha0, v);
      check("summary f2", v, 8'h10);
      host.read(2'd3, 8'hff, v);
      check("summary top", v, 8'h10);
      check("irq kept", {7'h00, irqOut_b}, 8'h00);
      host.poll(2'd2, status_irq_pkg::OFS_STATUS_A, 8'h04, v);
      settle();
      check("irq alarm read", {7'h00, irqOut_b}, 8'h01);
      level(2, 8'h00);
      settle();
      check("irq alarm off", {7'h00, irqOut_b}, 8'h00);
      host.poll(2'd2, status_irq_pkg::OFS_STATUS_A, 8'h04, v);
      settle();
      check("irq alarm done", {7'h00, irqOut_b}, 8'h01);
      // event interrupts from status_b and link status of framer 3
      host.write(2'd3, status_irq_pkg::OFS_MASK_B, 8'h80);
      host.write(2'd3, status_irq_pkg::OFS_LINK_MASK, 8'h01);
      pulse(3, 1, 8'h01);
      settle();
      check("irq ev masked", {7'h00, irqOut_b}, 8'h01);
      pulse(3, 1, 8'h80);
      pulse(3, 5, 8'h01);
      settle();
      check("irq event", {7'h00, irqOut_b}, 8'h00);
      host.read(2'd0, 8'ha0, v);
      check("summary f3", v, 8'hc0);
      host.poll(2'd3, status_irq_pkg::OFS_STATUS_B, 8'h80, v);
      settle();
      check("irq link left", {7'h00, irqOut_b}, 8'h00);
      host.read(2'd1, 8'hb7, v);
      check("summary link", v, 8'h80);
      host.poll(2'd3, status_irq_pkg::OFS_LINK_STATUS, 8'h01, v);
      settle();
      check("irq idle", {7'h00, irqOut_b}, 8'h01);
      summarize();
   end
endmodule : framer_status_latch_irq_test
`default_nettype wire
